// ---- hw/srp_regs.svh ----
// Register offsets, field positions, reset values and sizes of the mode packetizer
`ifndef SRP_REGS_SVH
`define SRP_REGS_SVH
`define SRP_ADDR_W        8
`define SRP_CTRL_OFS      8'h00
`define SRP_STAT_OFS      8'h04
`define SRP_CTRL_BAUD_LSB 0
`define SRP_CTRL_STRAT    3
`define SRP_CTRL_AIR_LSB  4
`define SRP_STAT_MODE_LSB 0
`define SRP_STAT_BUSY     2
`define SRP_STAT_DROP     3
`define SRP_STAT_CNT_LSB  16
`define SRP_BAUD_RST      3'h2
`define SRP_BAUD_CFG      3'h2
`define SRP_AIR_RST       5'h00
`define SRP_AIR_BASE      5'h02
`define SRP_BUF_DEPTH     4096
`define SRP_PTR_W         12
`define SRP_CNT_W         13
`define SRP_PKT_LEN       6'h37
`define SRP_PKT_LAST      6'h36
`endif

// ---- hw/srp_pkg.sv ----
// Types shared by the mode packetizer
package srp_pkg;
    typedef enum logic [1:0] {
        SRP_MODE_CONT,
        SRP_MODE_GEN,
        SRP_MODE_CFG,
        SRP_MODE_RSVD
    } srp_mode_e;

    typedef enum logic {
        SRP_TX_IDLE,
        SRP_TX_SEND
    } srp_tx_e;

    typedef struct packed {
        logic       first;
        logic       last;
        logic [7:0] data;
    } srp_air_s;

    typedef struct packed {
        logic [2:0] baud;
        logic       speed_first;
        logic [4:0] air_rate;
    } srp_cfg_s;
endpackage : srp_pkg

// ---- hw/srp_packetizer.sv ----
// Mode selection, 4096-byte buffer and radio framing of the serial radio modem
// Overview of operation
// R1: Both select inputs low gives continuous streaming mode.
// R2: Low select high, high select low gives packetized general mode.
// R3: Low select low, high select high gives configuration mode.
// R4: Both select inputs high gives the reserved mode.
// R5: Reserved mode neither sends nor accepts any radio data.
// R6: Continuous mode derives its air rate from the configured serial baud rate.
// R7: Continuous mode sends from the first byte until the buffer is empty.
// R8: Continuous mode uses the configured range-first or speed-first strategy.
// R9: General mode sends 55-byte packets at the configured air rate.
// R10: Longer bursts continue in further packets until the buffer drains.
// R11: Packets only in general mode, unbroken stream only in continuous mode. Configuration mode also sends its remote bytes as one unbroken stream.
// R12: Serial input alone starts a radio transmission in the data modes.
// R13: Half duplex: radio data is taken only while not transmitting.
// R14: Host never sends a burst larger than the 4096-byte buffer.
// R15: Configuration mode lets the host read and write the registers.
// R16: Configuration mode sends and accepts only remote configuration traffic.
// R17: Host uses 9600 baud in configuration mode.
// R18: Configuration mode fixes the serial format at 9600 baud, 8N1.
// R19: On buffer overrun excess bytes are dropped, buffered data kept.
//
// Design decisions made here: the strobed register port and the register addresses.
`timescale 1ns/1ps
`include "srp_regs.svh"

module srp_packetizer (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  mode_select_low,
    input  wire logic                  mode_select_high,
    input  wire logic                  host_valid,
    input  wire logic [7:0]            host_data,
    input  wire logic                  host_remote,
    output logic                       host_out_valid,
    output logic [7:0]                 host_out_data,
    output logic                       air_valid,
    output srp_pkg::srp_air_s          air_tx,
    input  wire logic                  air_ready,
    input  wire logic                  air_rx_valid,
    input  wire logic [7:0]            air_rx_data,
    input  wire logic                  air_rx_remote,
    output logic [4:0]                 air_rate,
    output logic                       air_speed_first,
    output logic [2:0]                 serial_baud,
    output logic                       serial_fixed_8n1,
    input  wire logic [`SRP_ADDR_W-1:0] reg_addr,
    input  wire logic [31:0]           reg_wdata,
    input  wire logic                  reg_we,
    input  wire logic                  reg_re,
    output logic [31:0]                reg_rdata
);
    import srp_pkg::*;

    // Decode of the two select inputs
    function automatic srp_mode_e mode_of(input logic hi, input logic lo);
        case ({hi, lo})
            // R1: continuous
            2'b00:   mode_of = SRP_MODE_CONT;
            // R2: general
            2'b01:   mode_of = SRP_MODE_GEN;
            // R3: configuration
            2'b10:   mode_of = SRP_MODE_CFG;
            // R4: reserved
            default: mode_of = SRP_MODE_RSVD;
        endcase
    endfunction : mode_of

    // Whether a host byte is bound for the radio in the given mode
    function automatic logic takes_host(input srp_mode_e m, input logic remote);
        case (m)
            SRP_MODE_CONT, SRP_MODE_GEN: takes_host = 1'b1;
            // R16: only remote commands leave while configuring
            SRP_MODE_CFG:                takes_host = remote;
            // R5: reserved mode sends nothing
            default:                     takes_host = 1'b0;
        endcase
    endfunction : takes_host

    srp_mode_e               mode;
    srp_cfg_s                cfg_q, cfg_d;
    logic [7:0]              buf_mem [`SRP_BUF_DEPTH];
    logic [`SRP_PTR_W-1:0]   wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
    logic [`SRP_CNT_W-1:0]   cnt_q, cnt_d;
    logic                    wr_en, rd_en, buf_full;
    srp_tx_e                 tx_state_q, tx_state_d;
    logic [5:0]              pkt_cnt_q, pkt_cnt_d;
    logic                    tx_valid_q, tx_valid_d;
    srp_air_s                tx_q, tx_d;
    logic                    drop_q, drop_d;
    logic                    hout_valid_q, hout_valid_d;
    logic [7:0]              hout_data_q, hout_data_d;
    logic [31:0]             rdata_q, rdata_d;

    assign mode      = mode_of(mode_select_high, mode_select_low);
    assign buf_full  = (cnt_q == `SRP_CNT_W'(`SRP_BUF_DEPTH));

    // Buffer fill and drain
    always_comb begin
        // R12: data modes buffer every host byte; R16: config mode only remote commands
        wr_en = host_valid && takes_host(mode, host_remote);
        // R19: overrun bytes dropped, buffered bytes untouched
        if (buf_full) begin
            wr_en = 1'b0;
        end
        // R5: reserved mode takes nothing for the radio
        if (mode == SRP_MODE_RSVD) begin
            wr_en = 1'b0;
        end
        rd_en    = 1'b0;
        if (mode != SRP_MODE_RSVD && cnt_q != '0 && (!tx_valid_q || air_ready)) begin
            rd_en = 1'b1;
        end
        wr_ptr_d = wr_en ? wr_ptr_q + 1'b1 : wr_ptr_q;
        rd_ptr_d = rd_en ? rd_ptr_q + 1'b1 : rd_ptr_q;
        cnt_d    = cnt_q + `SRP_CNT_W'(wr_en) - `SRP_CNT_W'(rd_en);
    end

    // Pointer and fill count registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            cnt_q    <= '0;
        end else begin
            wr_ptr_q <= wr_ptr_d;
            rd_ptr_q <= rd_ptr_d;
            cnt_q    <= cnt_d;
        end
    end

    // Byte storage, no reset needed
    always_ff @(posedge clk) begin
        if (wr_en) begin
            buf_mem[wr_ptr_q] <= host_data;
        end
    end

    // Radio transmit framing
    always_comb begin
        tx_state_d = tx_state_q;
        pkt_cnt_d  = pkt_cnt_q;
        tx_valid_d = tx_valid_q;
        tx_d       = tx_q;
        if (tx_valid_q && air_ready) begin
            tx_valid_d = 1'b0;
            if (tx_q.last) begin
                tx_state_d = SRP_TX_IDLE;
            end
        end
        if (rd_en) begin
            // R12: a buffered byte starts the transmission unasked
            tx_state_d   = SRP_TX_SEND;
            tx_valid_d   = 1'b1;
            tx_d.data    = buf_mem[rd_ptr_q];
            tx_d.first   = (pkt_cnt_q == '0);
            // R7: stream runs on until the buffer empties
            tx_d.last    = (cnt_d == '0) && !wr_en;
            // R11: count holds, no restart mid-stream
            if (pkt_cnt_q != `SRP_PKT_LAST) begin
                pkt_cnt_d = pkt_cnt_q + 1'b1;
            end
            // R9: general mode closes a packet at 55 bytes
            // R11: only general mode cuts the stream into packets
            if (mode == SRP_MODE_GEN && pkt_cnt_q == `SRP_PKT_LAST) begin
                tx_d.last = 1'b1;
            end
            // R10: remaining bytes start a further packet
            if (tx_d.last) begin
                pkt_cnt_d = '0;
            end
        end
        // R5: reserved mode abandons any transmission
        if (mode == SRP_MODE_RSVD) begin
            tx_state_d = SRP_TX_IDLE;
            tx_valid_d = 1'b0;
            pkt_cnt_d  = '0;
        end
    end

    // Transmit framing registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_state_q <= SRP_TX_IDLE;
            pkt_cnt_q  <= '0;
            tx_valid_q <= 1'b0;
            tx_q       <= '0;
        end else begin
            tx_state_q <= tx_state_d;
            pkt_cnt_q  <= pkt_cnt_d;
            tx_valid_q <= tx_valid_d;
            tx_q       <= tx_d;
        end
    end

    // Radio receive toward the host
    always_comb begin
        hout_valid_d = 1'b0;
        hout_data_d  = hout_data_q;
        case (mode)
            SRP_MODE_CONT, SRP_MODE_GEN: begin
                // R13: receive only while idle
                hout_valid_d = air_rx_valid && (tx_state_q == SRP_TX_IDLE);
            end
            SRP_MODE_CFG: begin
                // R16: only remote configuration answers pass
                hout_valid_d = air_rx_valid && air_rx_remote
                               && (tx_state_q == SRP_TX_IDLE);
            end
            // R5: reserved mode hears nothing
            SRP_MODE_RSVD: hout_valid_d = 1'b0;
            default:       hout_valid_d = 1'b0;
        endcase
        if (hout_valid_d) begin
            hout_data_d = air_rx_data;
        end
    end

    // Received byte registers toward the host
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hout_valid_q <= 1'b0;
            hout_data_q  <= '0;
        end else begin
            hout_valid_q <= hout_valid_d;
            hout_data_q  <= hout_data_d;
        end
    end

    // Register access, overrun flag and read data
    always_comb begin
        cfg_d   = cfg_q;
        drop_d  = drop_q;
        rdata_d = '0;
        // R15: settings writable only in configuration mode
        if (reg_we && reg_addr == `SRP_CTRL_OFS && mode == SRP_MODE_CFG) begin
            cfg_d.baud        = reg_wdata[`SRP_CTRL_BAUD_LSB +: 3];
            cfg_d.speed_first = reg_wdata[`SRP_CTRL_STRAT];
            cfg_d.air_rate    = reg_wdata[`SRP_CTRL_AIR_LSB +: 5];
        end
        if (reg_we && reg_addr == `SRP_STAT_OFS && reg_wdata[`SRP_STAT_DROP]) begin
            drop_d = 1'b0;
        end
        // R19: a dropped byte is recorded, set wins over clear
        if (host_valid && buf_full && takes_host(mode, host_remote)) begin
            drop_d = 1'b1;
        end
        if (reg_re) begin
            case (reg_addr)
                `SRP_CTRL_OFS: begin
                    rdata_d[`SRP_CTRL_BAUD_LSB +: 3] = cfg_q.baud;
                    rdata_d[`SRP_CTRL_STRAT]         = cfg_q.speed_first;
                    rdata_d[`SRP_CTRL_AIR_LSB +: 5]  = cfg_q.air_rate;
                end
                `SRP_STAT_OFS: begin
                    rdata_d[`SRP_STAT_MODE_LSB +: 2] = mode;
                    rdata_d[`SRP_STAT_BUSY]          = (tx_state_q == SRP_TX_SEND);
                    rdata_d[`SRP_STAT_DROP]          = drop_q;
                    rdata_d[`SRP_STAT_CNT_LSB +: `SRP_CNT_W] = cnt_q;
                end
                default: rdata_d = '0;
            endcase
        end
    end

    // Settings, overrun flag and read data registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q   <= '{baud: `SRP_BAUD_RST, speed_first: 1'b0, air_rate: `SRP_AIR_RST};
            drop_q  <= 1'b0;
            rdata_q <= '0;
        end else begin
            cfg_q   <= cfg_d;
            drop_q  <= drop_d;
            rdata_q <= rdata_d;
        end
    end

    // Link settings seen by the serial and radio front ends
    always_comb begin
        air_rate        = cfg_q.air_rate;
        air_speed_first = 1'b0;
        if (mode == SRP_MODE_CONT) begin
            // R6: air rate follows the serial baud rate
            air_rate        = `SRP_AIR_BASE + 5'(cfg_q.baud)
                              + 5'(cfg_q.speed_first);
            // R8: configured range or speed strategy
            air_speed_first = cfg_q.speed_first;
        end
        // R18: fixed 9600 8N1 while configuring
        serial_baud      = (mode == SRP_MODE_CFG) ? `SRP_BAUD_CFG : cfg_q.baud;
        serial_fixed_8n1 = (mode == SRP_MODE_CFG);
    end

    // Registered state onto the ports
    assign air_valid      = tx_valid_q;
    assign air_tx         = tx_q;
    assign host_out_valid = hout_valid_q;
    assign host_out_data  = hout_data_q;
    assign reg_rdata      = rdata_q;
endmodule : srp_packetizer

// ---- verification/srp_packetizer_properties.sv ----
// Checker for mode decoding, radio handshake and register read timing
`timescale 1ns/1ps
module srp_packetizer_properties (
    input wire logic              clk,
    input wire logic              rst_n,
    input wire logic              mode_select_low,
    input wire logic              mode_select_high,
    input wire logic              air_valid,
    input wire srp_pkg::srp_air_s air_tx,
    input wire logic              air_ready,
    input wire logic              air_rx_valid,
    input wire logic              air_rx_remote,
    input wire logic              host_out_valid,
    input wire logic [4:0]        air_rate,
    input wire logic              air_speed_first,
    input wire logic [2:0]        serial_baud,
    input wire logic              serial_fixed_8n1,
    input wire logic              reg_re,
    input wire logic [31:0]       reg_rdata
);
    import srp_pkg::*;
    logic m0;
    logic m2;
    logic m3;
    // Decoded select levels
    assign m0 = !mode_select_low && !mode_select_high;
    assign m2 = !mode_select_low && mode_select_high;
    assign m3 = mode_select_low && mode_select_high;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_rsvd_no_tx: assert property (m3 |=> !air_valid) else $error("tx in reserved mode");
    a_rsvd_no_rx: assert property (m3 && air_rx_valid |=> !host_out_valid) else $error("rx in reserved mode");
    a_tx_held: assert property (air_valid && !air_ready && !m3 |=> air_valid && $stable(air_tx)) else $error("tx byte not held");
    a_cfg_format: assert property (m2 |-> serial_baud == 3'h2 && serial_fixed_8n1) else $error("cfg serial format");
    a_half_duplex: assert property (air_rx_valid && air_valid |=> !host_out_valid) else $error("rx while sending");
    a_cfg_rx_only: assert property (m2 && air_rx_valid && !air_rx_remote |=> !host_out_valid) else $error("cfg rx filter");
    a_rdata_idle: assert property (!reg_re |=> reg_rdata == 32'h0) else $error("read data outside slot");
    a_speed_mode0: assert property (air_speed_first |-> m0) else $error("speed strategy outside mode 0");
    a_cont_rate: assert property (m0 |-> air_rate == 5'h02 + {2'h0, serial_baud} + {4'h0, air_speed_first}) else $error("cont air rate");
    c_last: cover property (air_valid && air_ready && air_tx.last);
    c_rx: cover property (air_rx_valid && !air_valid ##1 host_out_valid);
    c_rsvd: cover property (m3 && air_rx_valid);
endmodule : srp_packetizer_properties
bind srp_packetizer srp_packetizer_properties props (.*);

// ---- verification/srp_radio_model.sv ----
// Remote radio model taking transmitted bytes at a chosen pace
`timescale 1ns/1ps
module srp_radio_model (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              slow,
    input  wire logic              stop,
    input  wire logic              air_valid,
    input  wire srp_pkg::srp_air_s air_tx,
    output logic                   air_ready
);
    import srp_pkg::*;
    srp_air_s got[$];
    // Ready pattern, every other cycle when slow; capture of accepted bytes
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            air_ready <= 1'b0;
        end else begin
            if (air_valid && air_ready) begin
                got.push_back(air_tx);
            end
            air_ready <= !stop && (!slow || !air_ready);
        end
    end
endmodule : srp_radio_model

// ---- verification/srp_packetizer_tb.sv ----
// Self-checking bench of the mode packetizer
`timescale 1ns/1ps
module srp_packetizer_tb;
    import srp_pkg::*;
    logic clk = 0, rst_n = 0, msl = 0, msh = 0, hv = 0, rv = 0, rr = 0, we = 0, re = 0;
    logic slow = 0, stop = 0, hr = 0, hov, av, ardy, sf, f8;
    logic [7:0] hd = 0, rd_d = 0, hod, ra = 0;
    logic [31:0] wd = 0, rdata;
    logic [4:0] arate;
    logic [2:0] baud;
    srp_air_s atx;
    int mismatches = 0, compares = 0;
    always #2.5 clk = ~clk;
    srp_packetizer dut (.clk(clk), .rst_n(rst_n), .mode_select_low(msl), .mode_select_high(msh),
        .host_valid(hv), .host_data(hd), .host_remote(hr), .host_out_valid(hov),
        .host_out_data(hod), .air_valid(av), .air_tx(atx), .air_ready(ardy), .air_rx_valid(rv),
        .air_rx_data(rd_d), .air_rx_remote(rr), .air_rate(arate), .air_speed_first(sf),
        .serial_baud(baud), .serial_fixed_8n1(f8), .reg_addr(ra), .reg_wdata(wd),
        .reg_we(we), .reg_re(re), .reg_rdata(rdata));
    srp_radio_model radio (.clk(clk), .rst_n(rst_n), .slow(slow), .stop(stop),
        .air_valid(av), .air_tx(atx), .air_ready(ardy));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic test_done();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : test_done
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ra <= a;
        wd <= d;
        we <= 1'b1;
        @(posedge clk);
        we <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        ra <= a;
        re <= 1'b1;
        @(posedge clk);
        re <= 1'b0;
        #1 v = rdata;
        @(posedge clk);
    endtask : rd
    task automatic set_mode(input logic h, input logic l);
        msh <= h;
        msl <= l;
        repeat (4) @(posedge clk);
    endtask : set_mode
    task automatic send(input int n, input logic [7:0] b);
        for (int i = 0; i < n; i++) begin
            hv <= 1'b1;
            hd <= b + 8'(i);
            @(posedge clk);
        end
        hv <= 1'b0;
    endtask : send
    task automatic wait_got(input int n);
        for (int i = 0; i < 20000 && radio.got.size() < n; i++) @(posedge clk);
        repeat (10) @(posedge clk);
    endtask : wait_got
    // One radio byte in, expecting it at the host or not
    task automatic rx(input logic r, input logic exp);
        logic [7:0] d;
        d = r ? 8'ha5 : 8'h5a;
        rv <= 1'b1;
        rr <= r;
        rd_d <= d;
        @(posedge clk);
        rv <= 1'b0;
        #1 chk({hov, exp ? hod : d}, {exp, d});
        @(posedge clk);
    endtask : rx
    task automatic test_modes();
        logic [31:0] v;
        for (int m = 0; m < 4; m++) begin
            set_mode(m[1], m[0]);
            rd(8'h04, v);
            chk(v[1:0], m[1:0]);
            chk(f8, m == 2);
        end
        set_mode(1, 0);
        wr(8'h00, 32'h7d);
        rd(8'h00, v);
        chk(v[8:0], 9'h07d);
        chk(baud, 3'h2);
        rd(8'h40, v);
        chk(v, 0);
        set_mode(0, 0);
        chk({arate, sf, baud}, {5'h08, 1'b1, 3'h5});
        set_mode(0, 1);
        wr(8'h00, 32'h0);
        #1 chk({arate, sf}, {5'h07, 1'b0});
        @(posedge clk);
        $display("test modes done");
    endtask : test_modes
    // Sixty bytes against a slow far side; packet edges depend on mode
    task automatic test_burst(input logic gen);
        radio.got.delete();
        slow <= 1'b1;
        send(60, 8'h10);
        wait_got(60);
        chk(radio.got.size(), 60);
        for (int i = 0; i < 60; i++) begin
            chk(radio.got[i].first, i == 0 || (gen && i == 55));
            chk(radio.got[i].last, i == 59 || (gen && i == 54));
            chk(radio.got[i].data, 8'h10 + 8'(i));
        end
        $display("test burst done");
    endtask : test_burst
    task automatic test_rx();
        int n;
        rx(0, 1);
        set_mode(1, 0);
        rx(0, 0);
        rx(1, 1);
        n = radio.got.size();
        send(2, 8'h30);
        repeat (10) @(posedge clk);
        chk(radio.got.size(), n);
        hr <= 1'b1;
        send(1, 8'h40);
        hr <= 1'b0;
        wait_got(n + 1);
        chk(radio.got.size(), n + 1);
        chk(radio.got[n].data, 8'h40);
        set_mode(1, 1);
        n = radio.got.size();
        send(5, 8'h70);
        repeat (20) @(posedge clk);
        chk(radio.got.size(), n);
        rx(1, 0);
        $display("test rx done");
    endtask : test_rx
    task automatic test_drop();
        logic [31:0] v;
        set_mode(0, 1);
        radio.got.delete();
        stop <= 1'b1;
        send(4100, 8'h00);
        rd(8'h04, v);
        chk(v[3], 1'b1);
        chk(v[28:16], 13'h1000);
        chk(v[2], 1'b1);
        rx(0, 0);
        wr(8'h04, 32'h8);
        rd(8'h04, v);
        chk(v[3], 1'b0);
        stop <= 1'b0;
        slow <= 1'b0;
        wait_got(4097);
        chk(radio.got.size(), 4097);
        chk(radio.got[4096].data, 8'h00);
        $display("test drop done");
    endtask : test_drop
    initial begin
        #250000;
        mismatches++;
        test_done();
    end
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        test_modes();
        test_burst(1'b1);
        set_mode(0, 0);
        test_burst(1'b0);
        set_mode(0, 1);
        test_rx();
        test_drop();
        test_done();
    end
endmodule : srp_packetizer_tb
